// ===== core/ssr_pkg.sv
// Constants and types for the serial status and interrupt register block.
// Assumes a 32-bit APB slave port with byte addresses in the low bits.
package ssr_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SYNC_W = 16;
  localparam int LEN_W = 5;
  localparam int FLAG_N = 12;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TX_HOLD = 8'h24;
  localparam logic [7:0] OFF_RX_SYNC = 8'h30;
  localparam logic [7:0] OFF_TX_SYNC = 8'h34;
  localparam logic [7:0] OFF_CMP0 = 8'h38;
  localparam logic [7:0] OFF_CMP1 = 8'h3C;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_EN = 8'h44;
  localparam logic [7:0] OFF_IRQ_DIS = 8'h48;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h4C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_TX_BIT = 0;
  localparam int CTRL_RX_BIT = 1;
  localparam int SR_TX_ENABLED_BIT_BIT = 16;
  localparam int SR_RX_ENABLED_BIT_BIT = 17;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [11:0] RST_FLAGS = 12'h000;

  // Status flags, MSB first so bit 0 is the ready flag
  typedef struct packed {
    logic rxSyncEvent;
    logic txSyncEvent;
    logic compareOne;
    logic compareZero;
    logic rxDmaFullFlag;
    logic rxDmaDoneFlag;
    logic rxOverrunFlag;
    logic rxReadyFlag;
    logic txDmaIdleFlag;
    logic txDmaDoneFlag;
    logic txDrainedFlag;
    logic txReadyFlag;
  } ssr_flags_s;

endpackage

// ===== core/ssr_top.sv
// Status, sync holding, compare and interrupt mask registers of a
// synchronous serial controller, reached over APB.
// Assumes the shifters, DMA counters and event detectors run on mclk.
`timescale 1ns/1ps

// How it works
// - Transmit word masked to configured length
// - Ready flag low while holding word waits
// - Drained flag needs empty holding and shifter
// - DMA done on count zero, write clears
// - Transmit DMA idle when both counts zero
// - Receive ready tracks holding register contents
// - Overrun on reload before read; read clears
// - Receive DMA done on zero, write clears
// - Receive DMA full when both counts zero
// - Compare flags sticky until status read
// - Sync flags sticky until status read
// - Enable states shown at bits 16, 17
// - Enable register sets mask bits only
// - Sync holding registers sixteen bits wide
// - Compare zero value stored, read back
// - Compare one value stored, read back
// - Disable register clears mask bits only
// - Mask register reports enabled sources
module ssr_top (
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssr_pkg::DATA_W-1:0] pwdata,
  output logic [ssr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit path
  input wire logic [ssr_pkg::LEN_W-1:0] wordLength,
  input wire logic shiftLoad,
  input wire logic shiftBusy,
  output logic [ssr_pkg::DATA_W-1:0] txWord,
  output logic txWordValid,
  output logic [ssr_pkg::SYNC_W-1:0] txSyncWord,
  output logic txEnable,
  output logic rxEnable,
  // Receive path
  input wire logic rxLoad,
  input wire logic rxRead,
  input wire logic rxSyncLoad,
  input wire logic [ssr_pkg::SYNC_W-1:0] rxSyncWord,
  // DMA counter state
  input wire logic txCntZero,
  input wire logic txNextZero,
  input wire logic txCntWrite,
  input wire logic rxCntZero,
  input wire logic rxNextZero,
  input wire logic rxCntWrite,
  // Events
  input wire logic cmp0Event,
  input wire logic cmp1Event,
  input wire logic txSyncEvent,
  input wire logic rxSyncEvent,
  output logic irq
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic capture;   // Read data latched here
  logic apbDone;   // Writes take effect here
  logic mapped;
  logic wrDone;
  logic srRead;

  // One wait state: pready rises in the second access cycle
  assign capture = psel & penable & ~pready_reg;
  assign apbDone = psel & penable & pready_reg;
  assign wrDone = apbDone & pwrite;
  // Clear at capture so nothing lands between sample and clear
  assign srRead = capture & ~pwrite & (paddr == ssr_pkg::OFF_STATUS);

  always_comb begin
    unique case (paddr)
      ssr_pkg::OFF_CTRL, ssr_pkg::OFF_TX_HOLD,
      ssr_pkg::OFF_RX_SYNC, ssr_pkg::OFF_TX_SYNC,
      ssr_pkg::OFF_CMP0, ssr_pkg::OFF_CMP1,
      ssr_pkg::OFF_STATUS, ssr_pkg::OFF_IRQ_EN,
      ssr_pkg::OFF_IRQ_DIS, ssr_pkg::OFF_IRQ_MASK: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Write strobes per register
  logic wrCtrl;
  logic wrHold;
  logic wrTxSync;
  logic wrCmp0;
  logic wrCmp1;
  logic wrIrqEn;
  logic wrIrqDis;
  assign wrCtrl = wrDone & (paddr == ssr_pkg::OFF_CTRL);
  assign wrHold = wrDone & (paddr == ssr_pkg::OFF_TX_HOLD);
  assign wrTxSync = wrDone & (paddr == ssr_pkg::OFF_TX_SYNC);
  assign wrCmp0 = wrDone & (paddr == ssr_pkg::OFF_CMP0);
  assign wrCmp1 = wrDone & (paddr == ssr_pkg::OFF_CMP1);
  assign wrIrqEn = wrDone & (paddr == ssr_pkg::OFF_IRQ_EN);
  assign wrIrqDis = wrDone & (paddr == ssr_pkg::OFF_IRQ_DIS);

  // Ready and error handshake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= capture;
      // Unmapped addresses answer with an error
      pslverr_reg <= capture & ~mapped;
    end
  end

  // ----------------------------------------
  // Control and data registers
  // ----------------------------------------
  logic tx_enabled_bit_reg;
  logic rx_enabled_bit_reg;
  logic [31:0] txWord_reg;
  logic [15:0] txSync_reg;
  logic [15:0] rxSync_reg;
  logic [15:0] cmp0_reg;
  logic [15:0] cmp1_reg;
  logic [31:0] lenMask;

  // Low bits up to the configured length survive
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      assign lenMask[gi] = (gi <= int'(wordLength));
    end
  endgenerate

  // Enable bits steer the shifters outside
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_enabled_bit_reg <= 1'b0;
      rx_enabled_bit_reg <= 1'b0;
    end else if (wrCtrl) begin
      tx_enabled_bit_reg <= pwdata[ssr_pkg::CTRL_TX_BIT];
      rx_enabled_bit_reg <= pwdata[ssr_pkg::CTRL_RX_BIT];
    end
  end

  // Holding word stored right-justified, masked at write time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txWord_reg <= ssr_pkg::RST_WORD;
    end else if (wrHold) begin
      txWord_reg <= pwdata & lenMask;
    end
  end

  // Sync words: transmit side written by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txSync_reg <= ssr_pkg::RST_HALF;
    end else if (wrTxSync) begin
      txSync_reg <= pwdata[15:0];
    end
  end

  // Receive sync word loaded by the receiver only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxSync_reg <= ssr_pkg::RST_HALF;
    end else if (rxSyncLoad) begin
      rxSync_reg <= rxSyncWord;
    end
  end

  // Compare values, upper half reserved
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp0_reg <= ssr_pkg::RST_HALF;
      cmp1_reg <= ssr_pkg::RST_HALF;
    end else begin
      if (wrCmp0) begin
        cmp0_reg <= pwdata[15:0];
      end
      if (wrCmp1) begin
        cmp1_reg <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Transmit flags
  // ----------------------------------------
  logic holdFull_reg;
  logic holdFull_next;
  logic drained_reg;
  logic txDone_reg;
  logic txIdle_reg;
  logic txZeroPrev_reg;

  // A new write beats a same-cycle load: the new word waits
  assign holdFull_next = wrHold | (holdFull_reg & ~shiftLoad);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      holdFull_reg <= 1'b0;
    end else begin
      holdFull_reg <= holdFull_next;
    end
  end

  // Drained once holding is empty and shifter idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drained_reg <= 1'b1;
    end else begin
      drained_reg <= ~holdFull_next & ~shiftBusy & ~shiftLoad;
    end
  end

  // DMA done on the count reaching zero; set wins over write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txZeroPrev_reg <= 1'b0;
      txDone_reg <= 1'b0;
    end else begin
      txZeroPrev_reg <= txCntZero;
      if (txCntZero & ~txZeroPrev_reg) begin
        txDone_reg <= 1'b1;
      end else if (txCntWrite) begin
        txDone_reg <= 1'b0;
      end
    end
  end

  // Idle while both counters hold zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txIdle_reg <= 1'b0;
    end else begin
      txIdle_reg <= txCntZero & txNextZero;
    end
  end

  // ----------------------------------------
  // Receive flags
  // ----------------------------------------
  logic rx_ready_flag_reg;
  logic ovr_reg;
  logic rxDone_reg;
  logic rxFull_reg;
  logic rxZeroPrev_reg;

  // Ready while a word sits unread; a load beats a read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ready_flag_reg <= 1'b0;
    end else if (rxLoad) begin
      rx_ready_flag_reg <= 1'b1;
    end else if (rxRead) begin
      rx_ready_flag_reg <= 1'b0;
    end
  end

  // Overrun: reload of an unread word, cleared by status read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovr_reg <= 1'b0;
    end else if (rxLoad & rx_ready_flag_reg & ~rxRead) begin
      ovr_reg <= 1'b1;
    end else if (srRead) begin
      ovr_reg <= 1'b0;
    end
  end

  // Receive DMA done, cleared by counter write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxZeroPrev_reg <= 1'b0;
      rxDone_reg <= 1'b0;
    end else begin
      rxZeroPrev_reg <= rxCntZero;
      if (rxCntZero & ~rxZeroPrev_reg) begin
        rxDone_reg <= 1'b1;
      end else if (rxCntWrite) begin
        rxDone_reg <= 1'b0;
      end
    end
  end

  // Buffer full while both counters hold zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxFull_reg <= 1'b0;
    end else begin
      rxFull_reg <= rxCntZero & rxNextZero;
    end
  end

  // ----------------------------------------
  // Sticky event flags
  // ----------------------------------------
  logic [3:0] evt_reg;
  logic [3:0] evtIn;
  assign evtIn = {rxSyncEvent, txSyncEvent, cmp1Event, cmp0Event};

  // Event wins over a same-cycle status read
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          evt_reg[gi] <= 1'b0;
        end else if (evtIn[gi]) begin
          evt_reg[gi] <= 1'b1;
        end else if (srRead) begin
          evt_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Gather flags in status order
  ssr_pkg::ssr_flags_s flags;
  always_comb begin
    flags.rxSyncEvent = evt_reg[3];
    flags.txSyncEvent = evt_reg[2];
    flags.compareOne = evt_reg[1];
    flags.compareZero = evt_reg[0];
    flags.rxDmaFullFlag = rxFull_reg;
    flags.rxDmaDoneFlag = rxDone_reg;
    flags.rxOverrunFlag = ovr_reg;
    flags.rxReadyFlag = rx_ready_flag_reg;
    flags.txDmaIdleFlag = txIdle_reg;
    flags.txDmaDoneFlag = txDone_reg;
    flags.txDrainedFlag = drained_reg;
    flags.txReadyFlag = ~holdFull_reg;
  end

  // ----------------------------------------
  // Interrupt mask and output
  // ----------------------------------------
  logic [11:0] mask_reg;
  logic irq_reg;

  // Set by enable writes, cleared by disable writes; zeros ignored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_reg <= ssr_pkg::RST_FLAGS;
    end else if (wrIrqEn) begin
      mask_reg <= mask_reg | pwdata[11:0];
    end else if (wrIrqDis) begin
      mask_reg <= mask_reg & ~pwdata[11:0];
    end
  end

  // Registered so the pin never glitches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & mask_reg);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = ssr_pkg::RST_WORD;
    unique case (paddr)
      ssr_pkg::OFF_CTRL: begin
        rdMux[ssr_pkg::CTRL_TX_BIT] = tx_enabled_bit_reg;
        rdMux[ssr_pkg::CTRL_RX_BIT] = rx_enabled_bit_reg;
      end
      ssr_pkg::OFF_RX_SYNC: rdMux[15:0] = rxSync_reg;
      ssr_pkg::OFF_TX_SYNC: rdMux[15:0] = txSync_reg;
      ssr_pkg::OFF_CMP0: rdMux[15:0] = cmp0_reg;
      ssr_pkg::OFF_CMP1: rdMux[15:0] = cmp1_reg;
      ssr_pkg::OFF_STATUS: begin
        rdMux[11:0] = flags;
        rdMux[ssr_pkg::SR_TX_ENABLED_BIT_BIT] = tx_enabled_bit_reg;
        rdMux[ssr_pkg::SR_RX_ENABLED_BIT_BIT] = rx_enabled_bit_reg;
      end
      ssr_pkg::OFF_IRQ_MASK: rdMux[11:0] = mask_reg;
      // Write-only and unmapped words read zero
      default: rdMux = ssr_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_reg <= ssr_pkg::RST_WORD;
    end else if (capture & ~pwrite) begin
      prdata_reg <= rdMux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txWord = txWord_reg;
  assign txWordValid = holdFull_reg;
  assign txSyncWord = txSync_reg;
  assign txEnable = tx_enabled_bit_reg;
  assign rxEnable = rx_enabled_bit_reg;
  assign irq = irq_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  holdWaits_a: assert property (@(posedge mclk) disable iff (rst)
    wrHold |=> !flags.txReadyFlag)
    else $error("ready flag high after holding write");

  drainCause_a: assert property (@(posedge mclk) disable iff (rst)
    drained_reg |-> $past(!shiftBusy) && !holdFull_reg)
    else $error("drained flag with data pending");

  txDoneSet_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(txCntZero) |=> txDone_reg)
    else $error("transmit dma done not set");

  txIdleTrack_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 txIdle_reg == $past(txCntZero && txNextZero))
    else $error("transmit idle flag wrong");

  overrunSet_a: assert property (@(posedge mclk) disable iff (rst)
    rxLoad && rx_ready_flag_reg && !rxRead |=> ovr_reg ##1 (ovr_reg || $past(srRead)))
    else $error("overrun not held");

  cmpSticky_a: assert property (@(posedge mclk) disable iff (rst)
    cmp0Event ##1 (!srRead && !cmp0Event) |=> flags.compareZero)
    else $error("compare flag lost without read");

  syncClear_a: assert property (@(posedge mclk) disable iff (rst)
    srRead && !txSyncEvent |=> !flags.txSyncEvent)
    else $error("sync flag survived status read");

  maskSet_a: assert property (@(posedge mclk) disable iff (rst)
    wrIrqEn |=> mask_reg == ($past(mask_reg) | $past(pwdata[11:0])))
    else $error("enable write did not set mask");

  maskClr_a: assert property (@(posedge mclk) disable iff (rst)
    wrIrqDis |=> mask_reg == ($past(mask_reg) & ~$past(pwdata[11:0])))
    else $error("disable write did not clear mask");

  irqLevel_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 irq == $past(|(flags & mask_reg)))
    else $error("interrupt output mismatch");

  enBits_a: assert property (@(posedge mclk) disable iff (rst)
    srRead |=> prdata[ssr_pkg::SR_TX_ENABLED_BIT_BIT] == tx_enabled_bit_reg)
    else $error("status enable bit wrong");

endmodule

// ===== test/ssr_shift_model.sv
// Behavioural transmit shift engine that drains the holding register.
// Assumes the block's txWordValid level and a single mclk domain.
`timescale 1ns/1ps
module ssr_shift_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic txWordValid,
  output logic shiftLoad,
  output logic shiftBusy
);
  // ----------------------------------------
  // Shifter occupancy
  // ----------------------------------------
  localparam int BUSY_CYC = 12; // Longer than one status read, so busy is seen
  logic [3:0] busyCnt; // Cycles of sending left

  assign shiftBusy = (busyCnt != 4'h0);

  // Take a waiting word only when idle and not held off by the bench
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shiftLoad <= 1'b0;
      busyCnt <= 4'h0;
    end else if (shiftLoad) begin
      // Word taken: start sending it
      shiftLoad <= 1'b0;
      busyCnt <= 4'(BUSY_CYC);
    end else begin
      shiftLoad <= txWordValid && !stall && !shiftBusy;
      if (shiftBusy) begin
        busyCnt <= busyCnt - 4'h1;
      end
    end
  end
endmodule

// ===== test/ssr_top_tb.sv
// Self-checking bench for the serial status and interrupt registers.
// Assumes one APB wait state is not relied on: every wait polls pready.
`timescale 1ns/1ps
module ssr_top_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, txWord, rdVal;
  logic [15:0] txSyncWord, rxSyncWord;
  logic [4:0] wordLength;
  logic [8:0] ev; // Event and strobe pulses, one bit each
  logic [3:0] zeros; // DMA counter zero levels
  logic shiftLoad, shiftBusy, txWordValid, txEnable, rxEnable, stall;
  int fails, testsRun;
  logic [4:0] lens[4] = '{5'h01, 5'h07, 5'h0F, 5'h1F}; // Shortest to longest word
  logic [7:0] offs[3] = '{ssr_pkg::OFF_TX_SYNC, ssr_pkg::OFF_CMP0, ssr_pkg::OFF_CMP1};
  logic [15:0] vals[3] = '{16'h5A5A, 16'hC3E1, 16'h0FF0};

  ssr_top i_ssr_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wordLength(wordLength), .shiftLoad(shiftLoad), .shiftBusy(shiftBusy), .txWord(txWord),
    .txWordValid(txWordValid), .txSyncWord(txSyncWord), .txEnable(txEnable), .rxEnable(rxEnable),
    .rxLoad(ev[0]), .rxRead(ev[1]), .rxSyncLoad(ev[2]), .rxSyncWord(rxSyncWord),
    .txCntZero(zeros[0]), .txNextZero(zeros[1]), .txCntWrite(ev[3]), .rxCntZero(zeros[2]),
    .rxNextZero(zeros[3]), .rxCntWrite(ev[4]), .cmp0Event(ev[5]), .cmp1Event(ev[6]),
    .txSyncEvent(ev[7]), .rxSyncEvent(ev[8]), .irq(irq));

  ssr_shift_model i_ssr_shift_model (.mclk(mclk), .rst(rst), .stall(stall),
    .txWordValid(txWordValid), .shiftLoad(shiftLoad), .shiftBusy(shiftBusy));

  // ----------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("Checks run %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdVal & m, e);
  endtask

  // Single-cycle strobe on the chosen event lines
  task automatic pulse(input logic [8:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 9'h000;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wordLength = 5'h07;
    ev = 9'h000;
    zeros = 4'h0;
    rxSyncWord = 16'h0000;
    stall = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // Reset view: holding and shifter empty
    rdChk(ssr_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h3);
    rdChk(ssr_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Enable states mirrored in status
    apb(1'b1, ssr_pkg::OFF_CTRL, 32'h3);
    rdChk(ssr_pkg::OFF_STATUS, 32'h3_0000, 32'h3_0000);
    chk({30'h0, rxEnable, txEnable}, 32'h3);
    apb(1'b1, ssr_pkg::OFF_CTRL, 32'h1);
    rdChk(ssr_pkg::OFF_STATUS, 32'h3_0000, 32'h1_0000);
    // Transmit word through every length class, shifter held then released
    for (int i = 0; i < 4; i++) begin
      wordLength <= lens[i];
      stall <= 1'b1;
      apb(1'b1, ssr_pkg::OFF_TX_HOLD, 32'h9ABC_DEF7);
      rdChk(ssr_pkg::OFF_STATUS, 32'h3, 32'h0);
      chk(txWord, (32'hFFFF_FFFF >> (5'h1F - lens[i])) & 32'h9ABC_DEF7);
      chk({31'h0, txWordValid}, 32'h1);
      stall <= 1'b0;
      while (shiftLoad !== 1'b1) @(posedge mclk);
      rdChk(ssr_pkg::OFF_STATUS, 32'h3, 32'h1);
      chk({31'h0, txWordValid}, 32'h0);
      while (shiftBusy !== 1'b0) @(posedge mclk);
      rdChk(ssr_pkg::OFF_STATUS, 32'h3, 32'h3);
    end
    // DMA counters reach zero, then counter writes clear the done flags
    zeros <= 4'h5;
    rdChk(ssr_pkg::OFF_STATUS, 32'hCC, 32'h44);
    zeros <= 4'hF;
    rdChk(ssr_pkg::OFF_STATUS, 32'hCC, 32'hCC);
    pulse(9'h008);
    rdChk(ssr_pkg::OFF_STATUS, 32'hCC, 32'hC8);
    pulse(9'h010);
    rdChk(ssr_pkg::OFF_STATUS, 32'hCC, 32'h88);
    zeros <= 4'h0;
    rdChk(ssr_pkg::OFF_STATUS, 32'hCC, 32'h0);
    // Receive: ready, overrun on unread reload, read clears overrun
    pulse(9'h001);
    rdChk(ssr_pkg::OFF_STATUS, 32'h30, 32'h10);
    pulse(9'h001);
    rdChk(ssr_pkg::OFF_STATUS, 32'h30, 32'h30);
    rdChk(ssr_pkg::OFF_STATUS, 32'h30, 32'h10);
    pulse(9'h002);
    rdChk(ssr_pkg::OFF_STATUS, 32'h30, 32'h0);
    // Compare and sync flags stick until the next status read
    for (int k = 0; k < 4; k++) begin
      pulse(9'h020 << k);
      rdChk(ssr_pkg::OFF_STATUS, 32'hF00, 32'h100 << k);
      rdChk(ssr_pkg::OFF_STATUS, 32'hF00, 32'h0);
    end
    // Sync holding and compare registers
    rxSyncWord <= 16'hBEEF;
    pulse(9'h004);
    apb(1'b1, ssr_pkg::OFF_RX_SYNC, 32'h1234);
    rdChk(ssr_pkg::OFF_RX_SYNC, 32'hFFFF_FFFF, 32'hBEEF);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, offs[i], {16'hFFFF, vals[i]});
      rdChk(offs[i], 32'hFFFF_FFFF, {16'h0, vals[i]});
    end
    chk({16'h0, txSyncWord}, {16'h0, vals[0]});
    apb(1'b0, 8'h50, 32'h0);
    chk({rdVal[30:0], rdErr}, 32'h1);
    // Interrupt enable, disable, mask and output
    apb(1'b1, ssr_pkg::OFF_IRQ_EN, 32'h110);
    apb(1'b1, ssr_pkg::OFF_IRQ_EN, 32'h0);
    rdChk(ssr_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h110);
    chk({31'h0, irq}, 32'h0);
    pulse(9'h020);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rdChk(ssr_pkg::OFF_STATUS, 32'h100, 32'h100);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ssr_pkg::OFF_IRQ_DIS, 32'h100);
    apb(1'b1, ssr_pkg::OFF_IRQ_DIS, 32'h0);
    rdChk(ssr_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h10);
    pulse(9'h001);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ssr_pkg::OFF_IRQ_DIS, 32'h10);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wrap_up;
  end
endmodule
